// [hdl/xip_regs.vh]
// Purpose: constants for the extra external interrupt and auxiliary port block
// Assumes: byte-wide special function register space, 8-bit bit addresses
// Notes: included by the top module only
// How it works
// - control register bit addressable at c0h
// - bit address c2h sets irq2 enable
// - priority bits pick high or low level
// - irq2/irq3 request only while enabled
// - edge select one falling edge, zero low level
// - irq3 flag set on edge, cleared on vectoring
// - irq2 vectors to 33h, irq3 to 3bh
// - fixed polling order, vectors 03h step 08h
// - auxiliary port at d8h, byte and rmw access
// - only low four port bits implemented
// - quasi-bidirectional pins, read pin, write latch
// - port pins 3 and 2 feed irq2, irq3
// - port latch resets to all ones
// - control register resets to zero
`ifndef XIP_REGS_VH
`define XIP_REGS_VH

`define XIP_CTRL_ADDR 8'hc0
`define XIP_PORT_ADDR 8'hd8
`define XIP_CTRL_RESET 8'h00
`define XIP_PORT_RESET 4'hf
`define XIP_PORT_UNUSED 4'hf

`define XIP_IRQ3_HIGH_BIT 7
`define XIP_IRQ3_EN_BIT 6
`define XIP_IRQ3_FLAG_BIT 5
`define XIP_IRQ3_EDGE_BIT 4
`define XIP_IRQ2_HIGH_BIT 3
`define XIP_IRQ2_EN_BIT 2
`define XIP_IRQ2_FLAG_BIT 1
`define XIP_IRQ2_EDGE_BIT 0

`define XIP_IRQ2_PIN 3
`define XIP_IRQ3_PIN 2
`define XIP_IRQ2_SRC 3'h6
`define XIP_IRQ3_SRC 3'h7

`define XIP_VEC_BASE 8'h03
`define XIP_VEC_STEP 8'h08
`define XIP_MC_CLKS 12

`endif

// [hdl/xip_irq_chan.v]
// Purpose: one extra external interrupt input, sampling and request flag
// Assumes: pin level synchronous to clk, mc_tick one pulse per machine cycle
// Notes: level mode flag follows the last sample, nothing is latched
`timescale 1ns/1ps
`default_nettype none
module xip_irq_chan (
    input wire clk,
    input wire rst_n,
    input wire mc_tick,
    input wire pin_lvl,
    input wire edge_sel,
    input wire sw_wr,
    input wire sw_val,
    input wire hw_clr,
    output reg flag_ff
);
    reg samp_ff;
    reg nxt_samp;
    reg nxt_flag;
    wire fall_seen;

    // idle high sample at reset, so a pin already low at release is taken as an edge on the first tick
    assign fall_seen = mc_tick & samp_ff & ~pin_lvl;

    always @* begin
        nxt_samp = mc_tick ? pin_lvl : samp_ff;
        if (!edge_sel) begin
            nxt_flag = ~samp_ff;
        end else if (fall_seen) begin
            nxt_flag = 1'b1;
        end else if (hw_clr) begin
            nxt_flag = 1'b0;
        end else if (sw_wr) begin
            nxt_flag = sw_val;
        end else begin
            nxt_flag = flag_ff;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            samp_ff <= 1'b1;
            flag_ff <= 1'b0;
        end else begin
            samp_ff <= nxt_samp;
            flag_ff <= nxt_flag;
        end
    end
endmodule // xip_irq_chan
`default_nettype wire

// [hdl/xip_poll_enc.v]
// Purpose: two-level fixed-order poll of the eight interrupt sources
// Assumes: requests already gated by their enables
// Notes: purely combinational, the top registers the result
`timescale 1ns/1ps
`default_nettype none
module xip_poll_enc (
    input wire [7:0] req,
    input wire [7:0] high,
    output reg valid,
    output reg [2:0] src,
    output reg is_high
);
    integer i;
    reg [7:0] hreq;
    reg found;

    always @* begin
        hreq = req & high;
        valid = |req;
        is_high = |hreq;
        src = 3'h0;
        found = 1'b0;
        // lowest index wins inside the chosen level
        for (i = 0; i < 8; i = i + 1) begin
            if (!found && (is_high ? hreq[i] : req[i])) begin
                src = i[2:0];
                found = 1'b1;
            end
        end
    end
endmodule // xip_poll_enc
`default_nettype wire

// [hdl/xip_top.v]
// Purpose: extra external interrupts 2 and 3, their control register, aux port
// Assumes: core drives byte and bit strobes one cycle each, reads answer next cycle
// Notes: the other six sources arrive from the core already enabled
`timescale 1ns/1ps
`default_nettype none
`include "xip_regs.vh"
module xip_top #(
    parameter MC_CLKS = `XIP_MC_CLKS
) (
    input wire CLK,
    input wire RST_N,
    input wire [7:0] SFR_ADDR,
    input wire SFR_WR,
    input wire SFR_RD,
    input wire SFR_RMW,
    input wire [7:0] SFR_WDATA,
    output reg [7:0] SFR_RDATA,
    output reg SFR_HIT,
    input wire [7:0] BIT_ADDR,
    input wire BIT_SET,
    input wire BIT_CLR,
    input wire BIT_RD,
    output reg BIT_RDATA,
    input wire [3:0] PIN_IN,
    output reg [3:0] PIN_OUT,
    output reg [3:0] PIN_OE,
    input wire [5:0] CORE_REQ,
    input wire [5:0] CORE_HIGH,
    input wire INT_ACK,
    output reg INT_REQ,
    output reg [7:0] INT_VECTOR,
    output reg INT_HIGH,
    output reg [2:0] INT_SRC
);
    // bit address lands in the byte whose upper five bits it shares
    function bit_hits;
        input [7:0] baddr;
        input [7:0] base;
        begin
            bit_hits = (baddr[7:3] == base[7:3]);
        end
    endfunction

    function [7:0] vec_of;
        input [2:0] s;
        begin
            vec_of = `XIP_VEC_BASE + ({5'h00, s} * `XIP_VEC_STEP);
        end
    endfunction

    reg [3:0] div_ff;
    reg [3:0] nxt_div;
    reg mc_tick;
    reg [7:0] ctrl_ff;
    reg [7:0] nxt_ctrl;
    reg [3:0] latch_ff;
    reg [3:0] nxt_latch;
    reg [7:0] ctrl_mask;
    reg [7:0] ctrl_val;
    reg [7:0] port_mask;
    reg [7:0] port_val;
    reg [7:0] ctrl_view;
    reg [7:0] port_view;
    reg [7:0] nxt_rdata;
    reg nxt_hit;
    reg nxt_bit;
    wire bit_op;
    wire ctrl_byte;
    wire port_byte;
    wire ctrl_bit;
    wire port_bit;
    wire flag2;
    wire flag3;
    wire clr2;
    wire clr3;
    wire [7:0] all_req;
    wire [7:0] all_high;
    wire poll_valid;
    wire [2:0] poll_src;
    wire poll_high;

    // machine cycle enable from the system clock
    always @* begin
        if (div_ff == MC_CLKS[3:0] - 4'h1) begin
            nxt_div = 4'h0;
            mc_tick = 1'b1;
        end else begin
            nxt_div = div_ff + 4'h1;
            mc_tick = 1'b0;
        end
    end

    assign bit_op = BIT_SET | BIT_CLR;
    assign ctrl_byte = (SFR_ADDR == `XIP_CTRL_ADDR);
    assign port_byte = (SFR_ADDR == `XIP_PORT_ADDR);
    assign ctrl_bit = bit_hits(BIT_ADDR, `XIP_CTRL_ADDR);
    assign port_bit = bit_hits(BIT_ADDR, `XIP_PORT_ADDR);

    // byte write beats a bit operation in the same cycle
    always @* begin
        ctrl_mask = 8'h00;
        ctrl_val = 8'h00;
        port_mask = 8'h00;
        port_val = 8'h00;
        if (SFR_WR && ctrl_byte) begin
            ctrl_mask = 8'hff;
            ctrl_val = SFR_WDATA;
        end else if (bit_op && ctrl_bit) begin
            ctrl_mask = 8'h01 << BIT_ADDR[2:0];
            ctrl_val = BIT_SET ? 8'hff : 8'h00;
        end
        if (SFR_WR && port_byte) begin
            port_mask = 8'hff;
            port_val = SFR_WDATA;
        end else if (bit_op && port_bit) begin
            port_mask = 8'h01 << BIT_ADDR[2:0];
            port_val = BIT_SET ? 8'hff : 8'h00;
        end
        nxt_ctrl = (ctrl_ff & ~ctrl_mask) | (ctrl_val & ctrl_mask);
        nxt_latch = (latch_ff & ~port_mask[3:0]) | (port_val[3:0] & port_mask[3:0]);
    end

    // vectoring to a source clears its edge flag
    assign clr2 = INT_ACK & INT_REQ & (INT_SRC == `XIP_IRQ2_SRC);
    assign clr3 = INT_ACK & INT_REQ & (INT_SRC == `XIP_IRQ3_SRC);

    xip_irq_chan u_irq2 (
        .clk(CLK),
        .rst_n(RST_N),
        .mc_tick(mc_tick),
        .pin_lvl(PIN_IN[`XIP_IRQ2_PIN]),
        .edge_sel(ctrl_ff[`XIP_IRQ2_EDGE_BIT]),
        .sw_wr(ctrl_mask[`XIP_IRQ2_FLAG_BIT]),
        .sw_val(ctrl_val[`XIP_IRQ2_FLAG_BIT]),
        .hw_clr(clr2),
        .flag_ff(flag2)
    );

    xip_irq_chan u_irq3 (
        .clk(CLK),
        .rst_n(RST_N),
        .mc_tick(mc_tick),
        .pin_lvl(PIN_IN[`XIP_IRQ3_PIN]),
        .edge_sel(ctrl_ff[`XIP_IRQ3_EDGE_BIT]),
        .sw_wr(ctrl_mask[`XIP_IRQ3_FLAG_BIT]),
        .sw_val(ctrl_val[`XIP_IRQ3_FLAG_BIT]),
        .hw_clr(clr3),
        .flag_ff(flag3)
    );

    // level sources must stay low until serviced, nothing latches them
    assign all_req = {flag3 & ctrl_ff[`XIP_IRQ3_EN_BIT],
                      flag2 & ctrl_ff[`XIP_IRQ2_EN_BIT], CORE_REQ};
    assign all_high = {ctrl_ff[`XIP_IRQ3_HIGH_BIT],
                       ctrl_ff[`XIP_IRQ2_HIGH_BIT], CORE_HIGH};

    xip_poll_enc u_poll (
        .req(all_req),
        .high(all_high),
        .valid(poll_valid),
        .src(poll_src),
        .is_high(poll_high)
    );

    // read views: flags come from the channels, pins unless read-modify-write
    always @* begin
        ctrl_view = ctrl_ff;
        ctrl_view[`XIP_IRQ3_FLAG_BIT] = flag3;
        ctrl_view[`XIP_IRQ2_FLAG_BIT] = flag2;
        port_view = {`XIP_PORT_UNUSED, SFR_RMW ? latch_ff : PIN_IN};
        nxt_rdata = 8'h00;
        nxt_hit = 1'b0;
        nxt_bit = 1'b0;
        if (SFR_RD && ctrl_byte) begin
            nxt_rdata = ctrl_view;
            nxt_hit = 1'b1;
        end else if (SFR_RD && port_byte) begin
            nxt_rdata = port_view;
            nxt_hit = 1'b1;
        end
        if (BIT_RD && ctrl_bit) begin
            nxt_bit = ctrl_view[BIT_ADDR[2:0]];
        end else if (BIT_RD && port_bit) begin
            nxt_bit = port_view[BIT_ADDR[2:0]];
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            div_ff <= 4'h0;
            ctrl_ff <= `XIP_CTRL_RESET;
            latch_ff <= `XIP_PORT_RESET;
            SFR_RDATA <= 8'h00;
            SFR_HIT <= 1'b0;
            BIT_RDATA <= 1'b0;
            PIN_OUT <= 4'h0;
            PIN_OE <= 4'h0;
            INT_REQ <= 1'b0;
            INT_VECTOR <= 8'h00;
            INT_HIGH <= 1'b0;
            INT_SRC <= 3'h0;
        end else begin
            div_ff <= nxt_div;
            ctrl_ff <= nxt_ctrl;
            latch_ff <= nxt_latch;
            SFR_RDATA <= nxt_rdata;
            SFR_HIT <= nxt_hit;
            BIT_RDATA <= nxt_bit;
            // quasi-bidirectional: drive low only, a one is left to the pull-up
            PIN_OUT <= 4'h0;
            PIN_OE <= ~nxt_latch;
            INT_REQ <= poll_valid;
            INT_VECTOR <= poll_valid ? vec_of(poll_src) : 8'h00;
            INT_HIGH <= poll_valid & poll_high;
            INT_SRC <= poll_src;
        end
    end
endmodule // xip_top
`default_nettype wire

// [tb/xip_top_sva.sv]
// Purpose: port checks of the extra interrupt and aux port block
// Assumes: read answers come one cycle after the strobe
// Notes: watches a subset of the top ports only
`timescale 1ns/1ps
`default_nettype none
module xip_top_sva (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_RD,
    input wire logic SFR_RMW,
    input wire logic [7:0] SFR_RDATA,
    input wire logic SFR_HIT,
    input wire logic [7:0] BIT_ADDR,
    input wire logic BIT_RD,
    input wire logic BIT_RDATA,
    input wire logic [3:0] PIN_IN,
    input wire logic [3:0] PIN_OUT,
    input wire logic [3:0] PIN_OE,
    input wire logic INT_REQ,
    input wire logic [7:0] INT_VECTOR,
    input wire logic [2:0] INT_SRC
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire map_hit = (SFR_ADDR == 8'hc0) || (SFR_ADDR == 8'hd8);
    wire port_rd = SFR_RD && (SFR_ADDR == 8'hd8);
    a_hit_mapped: assert property (SFR_RD && map_hit |=> SFR_HIT)
        else $error("mapped read without hit");
    a_miss_quiet: assert property (SFR_RD && !map_hit |=> !SFR_HIT && SFR_RDATA == 8'h00)
        else $error("unmapped read answered");
    a_port_upper: assert property (port_rd |=> SFR_RDATA[7:4] == 4'hf)
        else $error("upper port bits not one");
    a_port_pins: assert property (port_rd && !SFR_RMW |=> SFR_RDATA[3:0] == $past(PIN_IN))
        else $error("port read not pin level");
    a_bit_upper: assert property (BIT_RD && BIT_ADDR[7:2] == 6'h37 |=> BIT_RDATA)
        else $error("upper port bit not one");
    a_bit_unmapped: assert property (BIT_RD && BIT_ADDR[7:3] != 5'h18
        && BIT_ADDR[7:3] != 5'h1b |=> !BIT_RDATA)
        else $error("unmapped bit read high");
    a_vec_of_src: assert property (INT_REQ |-> INT_VECTOR == {2'h0, INT_SRC, 3'h3})
        else $error("vector does not match source");
    a_idle_vec: assert property (!INT_REQ |-> INT_VECTOR == 8'h00)
        else $error("vector without request");
    a_pins_low: assert property (PIN_OUT == 4'h0)
        else $error("pin driven high");
    a_reset_latch: assert property ($rose(RST_N) |-> PIN_OE == 4'h0)
        else $error("port latch not ones after reset");
    cover property (INT_REQ && INT_SRC == 3'h6);
    cover property (INT_REQ && INT_SRC == 3'h7);
    cover property (INT_REQ && INT_SRC == 3'h0);
endmodule // xip_top_sva
bind xip_top xip_top_sva xip_top_sva_inst (.CLK, .RST_N, .SFR_ADDR, .SFR_RD, .SFR_RMW,
    .SFR_RDATA, .SFR_HIT, .BIT_ADDR, .BIT_RD, .BIT_RDATA, .PIN_IN, .PIN_OUT, .PIN_OE,
    .INT_REQ, .INT_VECTOR, .INT_SRC);
`default_nettype wire

// [tb/xip_pin_model.sv]
// Purpose: pins with pull-up and outside interrupt sources
// Assumes: sources only pull low
// Notes: pull-up wins unless block or source pulls low
`timescale 1ns/1ps
`default_nettype none
module xip_pin_model (
    input wire logic [3:0] oe,
    input wire logic [3:0] src_low,
    output logic [3:0] pin
);
    assign pin = ~(oe | src_low);
endmodule // xip_pin_model
`default_nettype wire

// [tb/xip_top_tb_top.sv]
// Purpose: self-checking bench of the extra interrupt and aux port block
// Assumes: machine cycle shortened to 4 clocks
// Notes: sources held low by the bench stand in for devices
`timescale 1ns/1ps
`default_nettype none
module xip_top_tb_top;
    logic CLK = 1'h0;
    logic RST_N = 1'h0;
    logic [7:0] SFR_ADDR = 8'h00;
    logic [7:0] SFR_WDATA = 8'h00;
    logic [7:0] BIT_ADDR = 8'h00;
    logic SFR_WR = 1'h0, SFR_RD = 1'h0, SFR_RMW = 1'h0, INT_ACK = 1'h0;
    logic BIT_SET = 1'h0, BIT_CLR = 1'h0, BIT_RD = 1'h0;
    logic [5:0] CORE_REQ = 6'h00, CORE_HIGH = 6'h00;
    logic [3:0] src_low = 4'h0;
    wire [7:0] SFR_RDATA, INT_VECTOR;
    wire SFR_HIT, BIT_RDATA, INT_REQ, INT_HIGH;
    wire [3:0] PIN_IN, PIN_OUT, PIN_OE;
    wire [2:0] INT_SRC;
    int error_cnt = 0;
    int checks = 0;
    always #5 CLK = ~CLK;
    xip_top #(.MC_CLKS(4)) xip_top_inst (.CLK, .RST_N, .SFR_ADDR, .SFR_WR, .SFR_RD,
        .SFR_RMW, .SFR_WDATA, .SFR_RDATA, .SFR_HIT, .BIT_ADDR, .BIT_SET, .BIT_CLR,
        .BIT_RD, .BIT_RDATA, .PIN_IN, .PIN_OUT, .PIN_OE, .CORE_REQ, .CORE_HIGH,
        .INT_ACK, .INT_REQ, .INT_VECTOR, .INT_HIGH, .INT_SRC);
    xip_pin_model xip_pin_model_inst (.oe(PIN_OE), .src_low(src_low), .pin(PIN_IN));
    task tally_and_finish;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task step(input int k);
        repeat (k) @(posedge CLK);
        #1;
    endtask
    task sfr(input logic wr, input logic rmw, input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        SFR_WR <= wr;
        SFR_RD <= !wr;
        SFR_RMW <= rmw;
        SFR_ADDR <= a;
        SFR_WDATA <= d;
        @(posedge CLK);
        SFR_WR <= 1'h0;
        SFR_RD <= 1'h0;
        #1;
    endtask
    task bop(input logic s, input logic c, input logic r, input logic [7:0] a);
        @(posedge CLK);
        BIT_SET <= s;
        BIT_CLR <= c;
        BIT_RD <= r;
        BIT_ADDR <= a;
        @(posedge CLK);
        {BIT_SET, BIT_CLR, BIT_RD} <= 3'h0;
        #1;
    endtask
    task pins(input logic [3:0] v);
        @(posedge CLK);
        src_low <= v;
    endtask
    task ack;
        @(posedge CLK);
        INT_ACK <= 1'h1;
        @(posedge CLK);
        INT_ACK <= 1'h0;
        step(2);
    endtask
    task wait_req(input logic v);
        int n;
        n = 0;
        while (INT_REQ !== v && n < 40) begin
            step(1);
            n++;
        end
        chk("int_req", {7'h0, INT_REQ}, {7'h0, v});
        if (n >= 40)
            tally_and_finish();
    endtask
    task t_reset;
        sfr(0, 0, 8'hc0, 8'h00);
        chk("ctrl", SFR_RDATA, 8'h00);
        sfr(0, 1, 8'hd8, 8'h00);
        chk("latch", SFR_RDATA, 8'hff);
        $display("t_reset done");
    endtask
    task t_regs;
        bop(1, 0, 0, 8'hc2);
        sfr(0, 0, 8'hc0, 8'h00);
        chk("ctrl_set", SFR_RDATA, 8'h04);
        bop(0, 0, 1, 8'hc2);
        chk("bit_rd", {7'h0, BIT_RDATA}, 8'h01);
        bop(0, 1, 0, 8'hc2);
        sfr(0, 0, 8'hc0, 8'h00);
        chk("ctrl_clr", SFR_RDATA, 8'h00);
        sfr(1, 0, 8'h90, 8'h55);
        sfr(0, 0, 8'h90, 8'h00);
        chk("unmapped", {SFR_HIT, SFR_RDATA[6:0]}, 8'h00);
        $display("t_regs done");
    endtask
    task t_port;
        sfr(1, 0, 8'hd8, 8'h0a);
        pins(4'h2);
        sfr(0, 0, 8'hd8, 8'h00);
        chk("pin_rd", SFR_RDATA, 8'hf8);
        chk("oe", {4'h0, PIN_OE}, 8'h05);
        bop(1, 0, 0, 8'hd8);
        sfr(0, 1, 8'hd8, 8'h00);
        chk("rmw_rd", SFR_RDATA, 8'hfb);
        sfr(1, 0, 8'hd8, 8'hff);
        pins(4'h0);
        // let a tick see the pins high, or a level flag leaks into edge mode
        step(12);
        $display("t_port done");
    endtask
    task t_edge;
        sfr(1, 0, 8'hc0, 8'h55);
        step(12);
        pins(4'h8);
        wait_req(1);
        chk("vec2", INT_VECTOR, 8'h33);
        pins(4'hc);
        step(12);
        chk("src_lo", {5'h0, INT_SRC}, 8'h06);
        bop(1, 0, 0, 8'hc7);
        step(2);
        chk("vec3", INT_VECTOR, 8'h3b);
        chk("high3", {7'h0, INT_HIGH}, 8'h01);
        ack;
        chk("after_ack3", INT_VECTOR, 8'h33);
        chk("low2", {7'h0, INT_HIGH}, 8'h00);
        sfr(0, 0, 8'hc0, 8'h00);
        chk("flags", SFR_RDATA, 8'hd7);
        @(posedge CLK);
        CORE_REQ <= 6'h01;
        step(2);
        chk("vec0", INT_VECTOR, 8'h03);
        @(posedge CLK);
        CORE_REQ <= 6'h00;
        step(2);
        ack;
        wait_req(0);
        pins(4'h0);
        // samples must be high again before the next scenario arms an edge
        step(12);
        $display("t_edge done");
    endtask
    task t_level;
        sfr(1, 0, 8'hc0, 8'h01);
        pins(4'h8);
        step(12);
        bop(0, 0, 1, 8'hc1);
        chk("flag_dis", {6'h0, INT_REQ, BIT_RDATA}, 8'h01);
        pins(4'h0);
        sfr(1, 0, 8'hc0, 8'h04);
        step(12);
        pins(4'h8);
        wait_req(1);
        ack;
        chk("lvl_hold", {7'h0, INT_REQ}, 8'h01);
        pins(4'h0);
        wait_req(0);
        $display("t_level done");
    endtask
    initial begin
        repeat (4) @(posedge CLK);
        RST_N <= 1'h1;
        t_reset;
        t_regs;
        t_port;
        t_edge;
        t_level;
        tally_and_finish;
    end
endmodule // xip_top_tb_top
`default_nettype wire
